// ===== logic/rx_frontend_config_and_agc.sv
// Front-end configuration decode, serial load port, Wishbone slave and gain loop
// Notes on behaviour
// RULE_01 - Amp select: auto, powered, passive, both off
// RULE_02 - Auto mode picks amp from feed current
// RULE_03 - Feed switch follows feed power bit
// RULE_04 - Bandpass bit; centre code only when bandpass
// RULE_05 - Order bit: 1 third, 0 fifth
// RULE_06 - Width code selects filter bandwidth
// RULE_07 - Centre word is seven bits wide
// RULE_08 - Host pairs centre and width codes
// RULE_09 - Manual gain code sets amplifier gain
// RULE_10 - Loop mode 10 uses manual gain
// RULE_11 - Count magnitude bits per 512-cycle window
// RULE_12 - Loop drives count toward density target
// RULE_13 - Host picks target such as 170
// RULE_14 - Detect output high when powered feed sensed
// RULE_15 - Serial data shifts on clock rise, select low
// RULE_16 - Step gain down if over, up if under
// RULE_17 - Gain code saturates, never wraps
//
// The placing of the registers and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rx_frontend_config_and_agc
  import rx_frontend_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Three-wire serial load port (asynchronous pins)
  input wire logic serial_clk_i,
  input wire logic serial_in_i,
  input wire logic serial_select_n_i,
  // Analog sense and converter inputs (asynchronous pins)
  input wire logic feed_current_sense_i,
  input wire logic adc_mag_i,
  // Front-end controls
  output logic feed_supply_pin_switch_o,
  output logic powered_feed_detect_out_o,
  output logic powered_input_amp_en_o,
  output logic passive_input_amp_en_o,
  output logic bandpass_select_o,
  output logic filter_order_select_o,
  output logic [1:0] filter_width_code_o,
  output logic [6:0] passband_centre_o,
  output logic [5:0] pga_gain_o
);
  // ****************************************
  // Synchronisers
  // ****************************************
  logic [1:0] sclk_sync; // Stage 0 only feeds stage 1
  logic [1:0] sdat_sync;
  logic [1:0] ssel_sync;
  logic [1:0] sense_sync;
  logic [1:0] mag_sync;
  logic sclk_prev; // Delayed copy for edge detection
  logic ssel_prev;
  logic sdat_late; // Data aligned with the edge detector

  // Every pin here is asynchronous to clk_i; a single flop could pass a
  // metastable level straight into the decode, so two stages are kept.
  // The extra delay is a few nanoseconds against much slower serial bits.
  // Two flops on every pin before use
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_sync <= 2'h0;
      sdat_sync <= 2'h0;
      ssel_sync <= 2'h3;
      sense_sync <= 2'h0;
      mag_sync <= 2'h0;
      sclk_prev <= 1'b0;
      ssel_prev <= 1'b1;
      sdat_late <= 1'b0;
    end else begin
      sclk_sync <= {sclk_sync[0], serial_clk_i};
      sdat_sync <= {sdat_sync[0], serial_in_i};
      ssel_sync <= {ssel_sync[0], serial_select_n_i};
      sense_sync <= {sense_sync[0], feed_current_sense_i};
      mag_sync <= {mag_sync[0], adc_mag_i};
      sclk_prev <= sclk_sync[1];
      ssel_prev <= ssel_sync[1];
      sdat_late <= sdat_sync[1];
    end
  end

  // ****************************************
  // Serial load port
  // ****************************************
  logic [31:0] ser_shift; // Frame being shifted in, MSB first
  logic [5:0] ser_count; // Bits seen in this frame, saturating
  wire sclk_rise = sclk_sync[1] & ~sclk_prev;
  wire ssel_low = ~ssel_prev;
  wire ssel_end = ssel_sync[1] & ~ssel_prev;
  // Frame is accepted only if exactly a full frame was shifted
  wire ser_done = ssel_end & (ser_count == SER_FRAME_LEN);
  wire [3:0] ser_idx = ser_shift[3:0];
  wire [15:0] ser_word = ser_shift[19:4];

  // The serial clock is oversampled by clk_i, so each of its phases must
  // last several clk_i periods or edges are lost.
  // A frame that is cut short leaves the words untouched, which is safer
  // than loading a half-shifted value into the front end.
  // Shift on each synchronised clock rise while select is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ser_shift <= 32'h00000000;
      ser_count <= 6'h00;
    end else if (!ssel_low) begin
      ser_count <= 6'h00;
    end else if (sclk_rise) begin
      ser_shift <= {ser_shift[SER_FRAME_BITS-2:0], sdat_late}; // RULE_15
      if (ser_count != 6'h3f) begin
        ser_count <= ser_count + 6'h01;
      end
    end
  end

  // ****************************************
  // Wishbone slave and configuration words
  // ****************************************
  logic [15:0] cfg1; // Antenna, amplifier and filter settings
  logic [15:0] cfg2; // Loop mode and density target
  logic [15:0] cfg3; // Manual gain
  logic [9:0] last_count; // Count of the latest closed window
  logic [5:0] auto_gain; // Gain code held by the loop
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_req & wb_we_i;
  wire [15:0] wb_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire wr_cfg1 = wb_wr & (wb_adr_i == ADDR_CFG1);
  wire wr_cfg2 = wb_wr & (wb_adr_i == ADDR_CFG2);
  wire wr_cfg3 = wb_wr & (wb_adr_i == ADDR_CFG3);
  wire ser_cfg1 = ser_done & (ser_idx == SER_IDX_CFG1);
  wire ser_cfg2 = ser_done & (ser_idx == SER_IDX_CFG2);
  wire ser_cfg3 = ser_done & (ser_idx == SER_IDX_CFG3);
  wire [15:0] next_cfg1_wb = (cfg1 & ~wb_mask) | (wb_dat_i[15:0] & wb_mask);
  wire [15:0] next_cfg2_wb = (cfg2 & ~wb_mask) | (wb_dat_i[15:0] & wb_mask);
  wire [15:0] next_cfg3_wb = (cfg3 & ~wb_mask) | (wb_dat_i[15:0] & wb_mask);
  wire [31:0] stat_word = {15'h0000, powered_feed_detect_out_o, last_count, auto_gain};
  // Unmapped addresses still answer, reading zero
  wire [31:0] next_rdata = (wb_adr_i == ADDR_CFG1) ? {16'h0000, cfg1} :
                           (wb_adr_i == ADDR_CFG2) ? {16'h0000, cfg2} :
                           (wb_adr_i == ADDR_CFG3) ? {16'h0000, cfg3} :
                           (wb_adr_i == ADDR_STAT) ? stat_word : 32'h00000000;

  // The request is masked by ack so a master that holds cyc and stb one
  // cycle too long does not get a second answer back to back.
  // Read data is forced to zero outside ack so stale values never leak.
  // One-wait-state answer; ack drops the cycle after it rose
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? next_rdata : 32'h00000000;
    end
  end

  // Serial load wins over a bus write landing in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg1 <= CFG1_RESET;
      cfg2 <= CFG2_RESET;
      cfg3 <= CFG3_RESET;
    end else begin
      if (ser_cfg1) begin
        cfg1 <= ser_word;
      end else if (wr_cfg1) begin
        cfg1 <= next_cfg1_wb;
      end
      if (ser_cfg2) begin
        cfg2 <= ser_word;
      end else if (wr_cfg2) begin
        cfg2 <= next_cfg2_wb;
      end
      if (ser_cfg3) begin
        cfg3 <= ser_word;
      end else if (wr_cfg3) begin
        cfg3 <= next_cfg3_wb;
      end
    end
  end

  // ****************************************
  // Field extraction
  // ****************************************
  // Plain slices of the words; positions live in the package so that the
  // bus map and the serial map can never drift apart.
  wire feed_on = cfg1[FEED_SWITCH_BIT];
  wire bandpass = cfg1[BANDPASS_BIT];
  wire third_order = cfg1[ORDER_BIT];
  wire [1:0] width_code = cfg1[WIDTH_LSB +: 2];
  wire [6:0] centre_word = {cfg1[CENTRE_TOP_BIT], cfg1[CENTRE_LSB +: 6]}; // RULE_07
  wire [1:0] amp_sel = cfg1[AMP_SEL_LSB +: 2];
  wire [9:0] target = cfg2[TARGET_LSB +: 10];
  wire [1:0] loop_mode = cfg2[LOOP_MODE_LSB +: 2];
  wire [5:0] manual_gain = cfg3[GAIN_LSB +: 6];

  // ****************************************
  // Antenna and amplifier decode
  // ****************************************
  // Current only flows with the bias switch closed, so sense is gated by it
  wire next_detect = sense_sync[1] & feed_on; // RULE_14
  logic next_powered_en;
  logic next_passive_en;

  // Amplifier choice; auto mode follows the feed sense
  always_comb begin
    case (amp_sel) // RULE_01
      AMP_AUTO: begin
        next_powered_en = next_detect; // RULE_02
        next_passive_en = ~next_detect; // RULE_02
      end
      AMP_POWERED: begin
        next_powered_en = 1'b1;
        next_passive_en = 1'b0;
      end
      AMP_PASSIVE: begin
        next_powered_en = 1'b0;
        next_passive_en = 1'b1;
      end
      default: begin
        next_powered_en = 1'b0;
        next_passive_en = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Gain loop
  // ****************************************
  logic [8:0] win_pos; // Cycle within the window
  logic [9:0] win_count; // Magnitude bits so far
  wire win_end = (win_pos == WINDOW_LAST);
  wire [9:0] final_count = win_count + {9'h000, mag_sync[1]};
  wire over = final_count > target;
  wire under = final_count < target;
  wire [5:0] gain_dn = (auto_gain == GAIN_MIN) ? GAIN_MIN : auto_gain - 6'h01; // RULE_17
  wire [5:0] gain_up = (auto_gain == GAIN_MAX) ? GAIN_MAX : auto_gain + 6'h01; // RULE_17
  // Too many magnitude hits means too much gain
  wire [5:0] next_auto_gain = over ? gain_dn : (under ? gain_up : auto_gain); // RULE_16
  // Loop keeps running in manual mode so a switch back resumes smoothly
  wire [5:0] next_gain = (loop_mode == LOOP_MANUAL) ? manual_gain : auto_gain; // RULE_10

  // One step per window keeps the loop slow and free of overshoot; a large
  // jump in signal level therefore takes many windows to settle.
  // The window counter wraps by itself, so no compare restarts it.
  // The count is ten bits wide so a window full of hits still fits.
  // Window counting and one gain step per window
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_pos <= 9'h000;
      win_count <= 10'h000;
      last_count <= 10'h000;
      auto_gain <= GAIN_RESET;
    end else begin
      win_pos <= win_pos + 9'h001; // RULE_11
      if (win_end) begin
        win_count <= 10'h000;
        last_count <= final_count; // RULE_11
        auto_gain <= next_auto_gain; // RULE_12
      end else begin
        win_count <= final_count;
      end
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  // Registering every pin costs one cycle of latency but keeps glitches
  // from the decode off the analog controls.
  // Every control pin comes straight from a flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      feed_supply_pin_switch_o <= 1'b0;
      powered_feed_detect_out_o <= 1'b0;
      powered_input_amp_en_o <= 1'b0;
      passive_input_amp_en_o <= 1'b0;
      bandpass_select_o <= 1'b0;
      filter_order_select_o <= 1'b0;
      filter_width_code_o <= 2'h0;
      passband_centre_o <= 7'h00;
      pga_gain_o <= GAIN_MIN;
    end else begin
      feed_supply_pin_switch_o <= feed_on; // RULE_03
      powered_feed_detect_out_o <= next_detect; // RULE_14
      powered_input_amp_en_o <= next_powered_en; // RULE_01
      passive_input_amp_en_o <= next_passive_en; // RULE_01
      bandpass_select_o <= bandpass; // RULE_04
      filter_order_select_o <= third_order; // RULE_05
      filter_width_code_o <= width_code; // RULE_06
      passband_centre_o <= bandpass ? centre_word : 7'h00; // RULE_04
      pga_gain_o <= next_gain; // RULE_09
    end
  end
endmodule : rx_frontend_config_and_agc
`default_nettype wire

// ===== logic/rx_frontend_pkg.sv
// Constants shared by the receiver front-end control block
package rx_frontend_pkg;
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [3:0] ADDR_CFG1 = 4'h0; // Antenna, amplifier and filter word
  localparam logic [3:0] ADDR_CFG2 = 4'h4; // Gain loop word
  localparam logic [3:0] ADDR_CFG3 = 4'h8; // Manual gain word
  localparam logic [3:0] ADDR_STAT = 4'hc; // Read-only status
  // Serial word index carried in the low nibble of a serial frame
  localparam logic [3:0] SER_IDX_CFG1 = 4'h1;
  localparam logic [3:0] SER_IDX_CFG2 = 4'h2;
  localparam logic [3:0] SER_IDX_CFG3 = 4'h3;
  localparam int SER_FRAME_BITS = 32;
  localparam logic [5:0] SER_FRAME_LEN = 6'h20;
  // ****************************************
  // Field positions, configuration word one
  // ****************************************
  localparam int FEED_SWITCH_BIT = 1;
  localparam int BANDPASS_BIT = 2;
  localparam int ORDER_BIT = 3;
  localparam int WIDTH_LSB = 4;
  localparam int CENTRE_LSB = 6;
  localparam int CENTRE_TOP_BIT = 12;
  localparam int AMP_SEL_LSB = 13;
  // ****************************************
  // Field positions, words two and three
  // ****************************************
  localparam int TARGET_LSB = 0;
  localparam int LOOP_MODE_LSB = 11;
  localparam int GAIN_LSB = 0;
  // ****************************************
  // Encodings and reset values
  // ****************************************
  localparam logic [1:0] AMP_AUTO = 2'h0;
  localparam logic [1:0] AMP_POWERED = 2'h1;
  localparam logic [1:0] AMP_PASSIVE = 2'h2;
  localparam logic [1:0] LOOP_MANUAL = 2'h2;
  localparam logic [15:0] CFG1_RESET = 16'h0000;
  localparam logic [15:0] CFG2_RESET = 16'h00aa; // Target of 170
  localparam logic [15:0] CFG3_RESET = 16'h0000;
  localparam logic [5:0] GAIN_MIN = 6'h00;
  localparam logic [5:0] GAIN_MAX = 6'h3f;
  localparam logic [5:0] GAIN_RESET = 6'h20;
  // ****************************************
  // Gain loop window
  // ****************************************
  localparam logic [8:0] WINDOW_LAST = 9'h1ff; // 512 cycles per window
endpackage : rx_frontend_pkg

// ===== testbench/rx_frontend_config_and_agc_tb.sv
// Self-checking bench for the front-end control block
`timescale 1ns/1ps
`default_nettype none
module rx_frontend_config_and_agc_tb;
  import rx_frontend_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [3:0] wb_adr = 4'h0, wb_sel = 4'h0;
  logic [31:0] wb_wdat = 32'h0, wb_rdat, rd;
  logic wb_ack, sclk, serial_in, sel_n, sense = 1'b0, mag = 1'b0, sw, det, pwr, pas, bp, ord;
  logic [1:0] wid;
  logic [6:0] cen;
  logic [5:0] gain, g;
  logic [15:0] c1;
  int err_total = 0, tests_run = 0, cycles = 0, dens = 0, n;
  always #2 clk_i = ~clk_i;
  // Random magnitude bits with density dens/8
  always @(posedge clk_i) mag <= int'($urandom() % 8) < dens;
  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 95000) begin
      err_total++;
      stop_test();
    end
  end
  rx_frontend_config_and_agc dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .serial_clk_i(sclk),
    .serial_in_i(serial_in), .serial_select_n_i(sel_n), .feed_current_sense_i(sense),
    .adc_mag_i(mag), .feed_supply_pin_switch_o(sw), .powered_feed_detect_out_o(det),
    .powered_input_amp_en_o(pwr), .passive_input_amp_en_o(pas), .bandpass_select_o(bp),
    .filter_order_select_o(ord), .filter_width_code_o(wid), .passband_centre_o(cen),
    .pga_gain_o(gain));
  rx_serial_host host_u (.clk_i(clk_i), .sclk_o(sclk), .serial_in_o(serial_in),
    .sel_n_o(sel_n));
  // ****************************************
  // Report, compare and bus tasks
  // ****************************************
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    n = 0;
    @(posedge clk_i);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat, wb_sel} <= {2'b11, w, a, d, 4'hf};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    rd = wb_rdat;
    if (n >= 50) err_total++;
    {wb_cyc, wb_stb} <= 2'b00;
  endtask : wb
  // Expected control outputs for a config word and sense level
  function automatic logic [14:0] exp_out(input logic [15:0] c, input logic s);
    logic d = s & c[1];
    logic [1:0] amp = (c[14:13] == 2'h0) ? {d, !d} : {c[14:13] == 2'h1, c[14:13] == 2'h2};
    return {c[1], d, amp, c[2], c[3], c[5:4], c[2] ? {c[12], c[11:6]} : 7'h0};
  endfunction : exp_out
  // Waits for the next gain step and checks it is one down, saturating
  task automatic step_down();
    g = gain;
    n = 0;
    while (gain === g && n < 600) begin
      @(posedge clk_i);
      n++;
    end
    chk(gain, (g == 6'h0) ? 6'h0 : g - 6'h1);
  endtask : step_down
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    void'($urandom(32'h92ed62f7));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, ADDR_CFG2, 0);
    chk(rd, 32'h00aa);
    // Unmapped word answers but keeps nothing
    wb(1, 4'h2, 32'hffff);
    wb(0, 4'h2, 0);
    chk(rd, 0);
    // Random config words; first four cover every amp code, first three the centre/width pairs
    for (int i = 0; i < 16; i++) begin
      c1 = 16'($urandom()) & 16'h7ffe;
      if (i < 4) c1[14:13] = i[1:0];
      if (i < 3) c1[11:4] = (i == 0) ? 8'h34 : (i == 1) ? 8'h36 : 8'hf5;
      sense <= 1'($urandom());
      wb(1, ADDR_CFG1, {16'h0, c1});
      repeat (6) @(posedge clk_i);
      chk({sw, det, pwr, pas, bp, ord, wid, cen}, exp_out(c1, sense));
      wb(0, ADDR_CFG1, 0);
      chk(rd, c1);
    end
    // Status word is read-only, so this write changes nothing
    wb(1, ADDR_STAT, 32'hffffffff);
    wb(0, ADDR_CFG1, 0);
    chk(rd, c1);
    // Serial load: manual mode, full and short frames
    host_u.send({12'($urandom()), 16'h10aa, SER_IDX_CFG2}, 32);
    host_u.send({12'h0, 16'h003f, SER_IDX_CFG3}, 32);
    chk(gain, 6'h3f);
    host_u.send({12'h0, 16'h0000, SER_IDX_CFG3}, 31);
    chk(gain, 6'h3f);
    // A full frame whose index names no word is dropped
    host_u.send({12'h0, 16'h0000, 4'h0}, 32);
    chk(gain, 6'h3f);
    host_u.send({12'h0, 16'h0000, SER_IDX_CFG3}, 32);
    chk(gain, 6'h00);
    wb(0, ADDR_CFG2, 0);
    chk(rd, 32'h10aa);
    // Automatic loop: dense bits pull the gain down to the floor
    wb(1, ADDR_CFG2, 32'h00aa);
    dens = 8;
    repeat (1100) @(posedge clk_i);
    repeat (3) step_down();
    repeat (32768) @(posedge clk_i);
    chk(gain, GAIN_MIN);
    wb(0, ADDR_STAT, 0);
    chk(32'(rd[15:6]), 32'd512);
    // Sparse bits push it up to the ceiling
    dens = 1;
    repeat (36000) @(posedge clk_i);
    chk(gain, GAIN_MAX);
    wb(0, ADDR_STAT, 0);
    chk(32'(rd[15:6] < 10'd170), 32'd1);
    // Second reset in mid-run restores defaults
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(gain, GAIN_RESET);
    wb(0, ADDR_CFG1, 0);
    chk(rd, 32'h0);
    stop_test();
  end
endmodule : rx_frontend_config_and_agc_tb
bind rx_frontend_config_and_agc rx_frontend_sva chk_u (.*);
`default_nettype wire

// ===== testbench/rx_frontend_sva.sv
// Port-level assertions for the front-end control block
`timescale 1ns/1ps
`default_nettype none
module rx_frontend_sva
  import rx_frontend_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic feed_supply_pin_switch_o,
  input wire logic powered_feed_detect_out_o,
  input wire logic powered_input_amp_en_o,
  input wire logic passive_input_amp_en_o,
  input wire logic bandpass_select_o,
  input wire logic [6:0] passband_centre_o,
  input wire logic [5:0] pga_gain_o
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****************************************
  // Bus handshake
  // ****************************************
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data not zero");
  // ****************************************
  // Front-end controls
  // ****************************************
  a_amp_exclusive: assert property (!(powered_input_amp_en_o && passive_input_amp_en_o))
    else $error("both amplifiers enabled");
  // Detect is gated by bias, allow one cycle for the switch to settle
  a_detect_bias: assert property (powered_feed_detect_out_o |->
    feed_supply_pin_switch_o || $past(feed_supply_pin_switch_o)) else $error("detect without bias");
  a_centre_lowpass: assert property (!bandpass_select_o && !$past(bandpass_select_o) |->
    passband_centre_o == 7'h0) else $error("centre code live in lowpass");
  a_gain_reset: assert property ($fell(rst_i) |-> ##[2:3] pga_gain_o == GAIN_RESET)
    else $error("gain not at reset value");
  c_read: cover property (wb_ack_o);
  c_powered: cover property (powered_feed_detect_out_o && powered_input_amp_en_o);
  c_gain_top: cover property (pga_gain_o == GAIN_MAX);
  c_bandpass: cover property (bandpass_select_o && passband_centre_o != 7'h0);
endmodule : rx_frontend_sva
`default_nettype wire

// ===== testbench/rx_serial_host.sv
// Behavioural host driving the three-wire serial load port
`timescale 1ns/1ps
`default_nettype none
module rx_serial_host (
  input wire logic clk_i,
  output logic sclk_o,
  output logic serial_in_o,
  output logic sel_n_o
);
  // Clock idles low and stands still between frames
  initial begin
    sclk_o = 1'b0;
    serial_in_o = 1'b0;
    sel_n_o = 1'b1;
  end
  // Shift MSB first; a short count gives a frame the block must drop
  task automatic send(input logic [31:0] frame, input int nbits);
    @(posedge clk_i);
    sel_n_o <= 1'b0;
    for (int i = 31; i > 31 - nbits; i--) begin
      repeat (4) @(posedge clk_i);
      serial_in_o <= frame[i];
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    sel_n_o <= 1'b1;
    serial_in_o <= ~serial_in_o; // Released line must not show a stale bit
    repeat (12) @(posedge clk_i);
  endtask : send
endmodule : rx_serial_host
`default_nettype wire
